// >>> src/cis_pkg.sv
package cis_pkg;
  // ---------------------------------------------------------------
  // addressing and register map
  // ---------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR  = 7'h6A;
  localparam logic [7:0] REG_STATUS  = 8'h00;
  localparam logic [7:0] REG_FAULT   = 8'h01;
  localparam logic [7:0] RD_UNMAPPED = 8'hFF;
  localparam logic [3:0] MASK_RESET  = 4'h0;
  localparam logic       SHIP_RESET  = 1'b0;
  localparam logic [1:0] STAT_FAULT  = 2'h3;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int SHIP_BIT = 5;
  localparam int OV_BIT   = 3;
  localparam int UV_BIT   = 2;
  localparam int BL_BIT   = 1;
  localparam int OC_BIT   = 0;
  localparam int MASK_W   = 4;
  localparam int BIT_CNT  = 8;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int LCLK_PERIOD_PS  = 15000;
  localparam int HANG_TIMEOUT_US = 25;
  localparam int HANG_CYCLES     = (HANG_TIMEOUT_US * 1000000) / LCLK_PERIOD_PS;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } cis_req_t;

  typedef struct packed {
    logic [1:0] charge_state;
    logic       input_dpm_active;
    logic       disable_pin_state;
    logic       switcher_on_state;
    logic       reset_cond;
    logic       timer_fault;
    logic       input_ov;
    logic       input_uv;
    logic       battery_low;
    logic       battery_oc;
  } cis_cond_t;

  typedef enum logic [2:0] {LS_IDLE, LS_RX, LS_ACK, LS_TX, LS_MACK} cis_lst_t;
  typedef enum logic [1:0] {K_ADDR, K_REG, K_DATA} cis_kind_t;
endpackage

// >>> src/cis_charger_i2c.sv
`timescale 1ns/1ps
// Function
// - slave only; protocol identical at 100 and 400 kbit/s
// - seven-bit addressing, own address 0x6A (0xD4 with direction bit)
// - data line low past the hang timeout resets the serial engine
// - hang timer restarts on start, halts on valid stop
// - start is falling data while clock high
// - transmitter changes data only while clock is low
// - acknowledge only on address match, low through ninth clock
// - direction zero master writes, one device reads out
// - each byte followed by receiver acknowledge, repeating freely
// - stop is rising data while clock high; release and idle
// - read of unmapped register returns all ones
// - status top bits show live charge state, fault as 11
// - status bit five write-only ship mode request, reset zero
// - status bit four pushbutton reset flag clears on read
// - status bit three timer fault holds until disable pin toggles
// - status low bits show dpm, disable pin and switcher live
// - overvoltage and battery-low flags hold while condition persists
// - input undervoltage flag shows once per new event
// - battery overcurrent flag clears on read
// - fault bits three to zero are masks, reset zero
// - fault sets flag even when masked; unmasked fault sets fault state and interrupt output
module cis_charger_i2c
  import cis_pkg::*;
#(
  parameter int HANG_CYC = HANG_CYCLES
) (
  input  wire logic      mclk,
  input  wire logic      arst_n,
  input  wire logic      lclk,
  input  wire logic      scl_i,
  input  wire logic      sda_i,
  output logic           sda_o,
  output logic           sda_oe,
  input  wire cis_cond_t cond,
  output logic           ship_mode_request,
  output logic           int_req
);

  localparam int HW = $clog2(HANG_CYC + 1);

  if (HANG_CYC < 2) begin : g_bad_hang
    $error("hang timeout must be at least two cycles");
  end

  function automatic logic rd_hit(input cis_req_t q, input logic [7:0] a);
    return !q.wr && (q.addr == a);
  endfunction

  // ---------------------------------------------------------------
  // link side: synchronisers and bus events
  // ---------------------------------------------------------------
  logic           scl_s1_r, scl_s2_r, scl_s3_r;
  logic           sda_s1_r, sda_s2_r, sda_s3_r;
  logic           ack_s1_r, ack_s2_r, ack_s3_r;
  logic           req_tgl_r;
  logic           ack_tgl_r;
  cis_req_t       lnk_req_r;
  logic [7:0]     rd_data_r;
  logic [7:0]     rd_word_r;
  cis_lst_t       lst_r;
  cis_kind_t      kind_r;
  logic [3:0]     cnt_r;
  logic [7:0]     shf_r;
  logic [7:0]     tx_r;
  logic [7:0]     ptr_r;
  logic           rw_r;
  logic           mack_r;
  logic           sda_oe_r;
  logic [HW-1:0]  hang_r;

  always_ff @(posedge lclk or negedge arst_n) begin
    if (!arst_n) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_s3_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_s3_r <= 1'b1;
    end else begin
      scl_s1_r <= scl_i;
      scl_s2_r <= scl_s1_r;
      scl_s3_r <= scl_s2_r;
      sda_s1_r <= sda_i;
      sda_s2_r <= sda_s1_r;
      sda_s3_r <= sda_s2_r;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop, hang_hit;
  assign scl_rise  = scl_s2_r & ~scl_s3_r;
  assign scl_fall  = ~scl_s2_r & scl_s3_r;
  assign bus_start = scl_s2_r & scl_s3_r & sda_s3_r & ~sda_s2_r;
  assign bus_stop  = scl_s2_r & scl_s3_r & ~sda_s3_r & sda_s2_r;
  assign hang_hit  = (hang_r == HW'(HANG_CYC - 1)) && !sda_s2_r && (lst_r != LS_IDLE);

  always_ff @(posedge lclk or negedge arst_n) begin
    if (!arst_n) begin
      hang_r <= '0;
    end else if (bus_start || lst_r == LS_IDLE || sda_s2_r) begin
      hang_r <= '0;
    end else if (hang_r != HW'(HANG_CYC - 1)) begin
      hang_r <= hang_r + 1'b1;
    end
  end

  // read data returns by toggle handshake
  always_ff @(posedge lclk or negedge arst_n) begin
    if (!arst_n) begin
      ack_s1_r  <= 1'b0;
      ack_s2_r  <= 1'b0;
      ack_s3_r  <= 1'b0;
      rd_word_r <= RD_UNMAPPED;
    end else begin
      ack_s1_r <= ack_tgl_r;
      ack_s2_r <= ack_s1_r;
      ack_s3_r <= ack_s2_r;
      if (ack_s2_r ^ ack_s3_r) begin
        rd_word_r <= rd_data_r;
      end
    end
  end

  // ---------------------------------------------------------------
  // link side: serial engine
  // ---------------------------------------------------------------
  always_ff @(posedge lclk or negedge arst_n) begin
    if (!arst_n) begin
      lst_r     <= LS_IDLE;
      kind_r    <= K_ADDR;
      cnt_r     <= '0;
      shf_r     <= '0;
      tx_r      <= '0;
      ptr_r     <= '0;
      rw_r      <= 1'b0;
      mack_r    <= 1'b0;
      sda_oe_r  <= 1'b0;
      req_tgl_r <= 1'b0;
      lnk_req_r <= '0;
    end else if (bus_start) begin
      lst_r    <= LS_RX;
      kind_r   <= K_ADDR;
      cnt_r    <= '0;
      sda_oe_r <= 1'b0;
    end else if (bus_stop || hang_hit) begin
      // engine reset, rest of transfer ignored
      lst_r    <= LS_IDLE;
      sda_oe_r <= 1'b0;
    end else begin
      unique case (lst_r)
        LS_IDLE: begin
          sda_oe_r <= 1'b0;
        end
        LS_RX: begin
          if (scl_rise) begin
            shf_r <= {shf_r[6:0], sda_s2_r};
            cnt_r <= cnt_r + 1'b1;
          end else if (scl_fall && cnt_r == 4'(BIT_CNT)) begin
            unique case (kind_r)
              K_ADDR: begin
                if (shf_r[7:1] == SLAVE_ADDR) begin
                  rw_r     <= shf_r[0];
                  kind_r   <= K_REG;
                  lst_r    <= LS_ACK;
                  sda_oe_r <= 1'b1;
                  if (shf_r[0]) begin
                    req_tgl_r <= ~req_tgl_r;
                    lnk_req_r <= '{wr: 1'b0, addr: ptr_r, data: 8'h00};
                    ptr_r     <= ptr_r + 1'b1;
                  end
                end else begin
                  lst_r <= LS_IDLE;
                end
              end
              K_REG: begin
                ptr_r    <= shf_r;
                kind_r   <= K_DATA;
                lst_r    <= LS_ACK;
                sda_oe_r <= 1'b1;
              end
              K_DATA: begin
                req_tgl_r <= ~req_tgl_r;
                lnk_req_r <= '{wr: 1'b1, addr: ptr_r, data: shf_r};
                ptr_r     <= ptr_r + 1'b1;
                lst_r     <= LS_ACK;
                sda_oe_r  <= 1'b1;
              end
              default: lst_r <= LS_IDLE;
            endcase
          end
        end
        LS_ACK: begin
          if (scl_fall) begin
            if (rw_r) begin
              tx_r     <= rd_word_r;
              sda_oe_r <= ~rd_word_r[7];
              cnt_r    <= 4'h1;
              lst_r    <= LS_TX;
            end else begin
              sda_oe_r <= 1'b0;
              cnt_r    <= '0;
              lst_r    <= LS_RX;
            end
          end
        end
        LS_TX: begin
          if (scl_fall) begin
            if (cnt_r == 4'(BIT_CNT)) begin
              sda_oe_r <= 1'b0;
              lst_r    <= LS_MACK;
            end else begin
              sda_oe_r <= ~tx_r[6];
              tx_r     <= {tx_r[6:0], 1'b0};
              cnt_r    <= cnt_r + 1'b1;
            end
          end
        end
        LS_MACK: begin
          if (scl_rise) begin
            mack_r <= ~sda_s2_r;
            if (!sda_s2_r) begin
              req_tgl_r <= ~req_tgl_r;
              lnk_req_r <= '{wr: 1'b0, addr: ptr_r, data: 8'h00};
              ptr_r     <= ptr_r + 1'b1;
            end
          end else if (scl_fall) begin
            if (mack_r) begin
              tx_r     <= rd_word_r;
              sda_oe_r <= ~rd_word_r[7];
              cnt_r    <= 4'h1;
              lst_r    <= LS_TX;
            end else begin
              lst_r <= LS_IDLE;
            end
          end
        end
        default: lst_r <= LS_IDLE;
      endcase
    end
  end

  assign sda_o  = 1'b0;
  assign sda_oe = sda_oe_r;

  // ---------------------------------------------------------------
  // core side: request crossing
  // ---------------------------------------------------------------
  logic req_s1_r, req_s2_r, req_s3_r;
  logic req_edge, rd0, rd1, wr0, wr1;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      req_s1_r <= 1'b0;
      req_s2_r <= 1'b0;
      req_s3_r <= 1'b0;
    end else begin
      req_s1_r <= req_tgl_r;
      req_s2_r <= req_s1_r;
      req_s3_r <= req_s2_r;
    end
  end

  assign req_edge = req_s2_r ^ req_s3_r;
  assign rd0      = req_edge && rd_hit(lnk_req_r, REG_STATUS);
  assign rd1      = req_edge && rd_hit(lnk_req_r, REG_FAULT);
  assign wr0      = req_edge && lnk_req_r.wr && lnk_req_r.addr == REG_STATUS;
  assign wr1      = req_edge && lnk_req_r.wr && lnk_req_r.addr == REG_FAULT;

  // ---------------------------------------------------------------
  // core side: registers and flags
  // ---------------------------------------------------------------
  logic [MASK_W-1:0] mask_r;
  logic [MASK_W-1:0] flag_r;
  logic              ship_r, rstf_r, tmr_r, cd_prev_r, uv_prev_r, int_r;
  logic              fault_any;
  logic [1:0]        stat;
  logic [7:0]        status_byte;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ship_r <= SHIP_RESET;
      mask_r <= MASK_RESET;
    end else begin
      if (wr0) begin
        ship_r <= lnk_req_r.data[SHIP_BIT];
      end
      if (wr1) begin
        mask_r <= lnk_req_r.data[MASK_W-1:0];
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      flag_r    <= '0;
      rstf_r    <= 1'b0;
      tmr_r     <= 1'b0;
      cd_prev_r <= 1'b0;
      uv_prev_r <= 1'b0;
    end else begin
      cd_prev_r <= cond.disable_pin_state;
      uv_prev_r <= cond.input_uv;
      rstf_r <= cond.reset_cond | (rstf_r & ~rd0);
      // cleared only by disable pin toggle
      tmr_r <= cond.timer_fault | (tmr_r & (cond.disable_pin_state == cd_prev_r));
      flag_r[OV_BIT] <= cond.input_ov | (flag_r[OV_BIT] & ~rd1);
      flag_r[BL_BIT] <= cond.battery_low | (flag_r[BL_BIT] & ~rd1);
      flag_r[UV_BIT] <= (cond.input_uv & ~uv_prev_r) | (flag_r[UV_BIT] & ~rd1);
      flag_r[OC_BIT] <= cond.battery_oc | (flag_r[OC_BIT] & ~rd1);
    end
  end

  assign fault_any   = (|(flag_r & ~mask_r)) | tmr_r;
  assign stat        = fault_any ? STAT_FAULT : cond.charge_state;
  assign status_byte = {stat, 1'b0, rstf_r, tmr_r, cond.input_dpm_active,
                        cond.disable_pin_state, cond.switcher_on_state};

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_r <= RD_UNMAPPED;
      ack_tgl_r <= 1'b0;
    end else if (req_edge) begin
      ack_tgl_r <= ~ack_tgl_r;
      if (rd0) begin
        rd_data_r <= status_byte;
      end else if (rd1) begin
        rd_data_r <= {flag_r, mask_r};
      end else if (!lnk_req_r.wr) begin
        rd_data_r <= RD_UNMAPPED;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      int_r <= 1'b0;
    end else begin
      int_r <= fault_any;
    end
  end

  assign ship_mode_request = ship_r;
  assign int_req           = int_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_ship_write: assert property (@(posedge mclk) disable iff (!arst_n)
    wr0 |=> ship_r == $past(lnk_req_r.data[SHIP_BIT]))
    else $error("ship request not taken from write");
  chk_unmapped_read: assert property (@(posedge mclk) disable iff (!arst_n)
    (req_edge && !lnk_req_r.wr && lnk_req_r.addr > REG_FAULT) |=> rd_data_r == RD_UNMAPPED)
    else $error("unmapped read not all ones");
  chk_rstf_clear: assert property (@(posedge mclk) disable iff (!arst_n)
    (rd0 && !cond.reset_cond) |=> !rstf_r)
    else $error("reset flag not cleared by read");
  chk_timer_hold: assert property (@(posedge mclk) disable iff (!arst_n)
    (tmr_r && cond.disable_pin_state == cd_prev_r) |=> tmr_r)
    else $error("timer fault lost without pin toggle");
  chk_ov_persist: assert property (@(posedge mclk) disable iff (!arst_n)
    cond.input_ov |=> flag_r[OV_BIT])
    else $error("overvoltage flag dropped while present");
  chk_uv_once: assert property (@(posedge mclk) disable iff (!arst_n)
    (rd1 && !(cond.input_uv && !uv_prev_r)) |=> !flag_r[UV_BIT])
    else $error("undervoltage flag shown twice");
  chk_oc_clear: assert property (@(posedge mclk) disable iff (!arst_n)
    (rd1 && !cond.battery_oc) |=> !flag_r[OC_BIT])
    else $error("overcurrent flag not cleared by read");
  chk_fault_int: assert property (@(posedge mclk) disable iff (!arst_n)
    fault_any |=> int_r)
    else $error("fault not signalled");
  chk_fault_state: assert property (@(posedge mclk) disable iff (!arst_n)
    (rd0 && fault_any) |=> rd_data_r[7:6] == STAT_FAULT)
    else $error("fault state not reported");
  chk_hang_reset: assert property (@(posedge lclk) disable iff (!arst_n)
    (hang_hit && !bus_start) |=> lst_r == LS_IDLE && !sda_oe_r)
    else $error("hang timeout did not reset engine");
  chk_addr_nack: assert property (@(posedge lclk) disable iff (!arst_n)
    (lst_r == LS_RX && kind_r == K_ADDR && scl_fall && cnt_r == 4'(BIT_CNT) &&
     shf_r[7:1] != SLAVE_ADDR && !bus_start && !bus_stop && !hang_hit) |=> !sda_oe_r)
    else $error("acknowledged foreign address");

endmodule

// >>> test/cis_bus_master.sv
`timescale 1ns/1ps
module cis_bus_master (
  input  wire logic mclk,
  input  wire logic sda,
  output logic      scl,
  output logic      m_pull
);
  // ---------------------------------------------------------------
  // idle bus: clock high and still, data released to the pull-up
  // ---------------------------------------------------------------
  initial begin
    scl    = 1'b1;
    m_pull = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic start();
    m_pull = 1'b0;
    tick(3);
    scl = 1'b1;
    tick(5);
    m_pull = 1'b1;
    tick(5);
    scl = 1'b0;
    tick(2);
  endtask

  task automatic stop();
    m_pull = 1'b1;
    tick(3);
    scl = 1'b1;
    tick(5);
    m_pull = 1'b0;
    tick(5);
  endtask

  // data changes only while clock low
  task automatic xfer_bit(input logic b, output logic s);
    m_pull = ~b;
    tick(3);
    scl = 1'b1;
    tick(3);
    s = sda;
    tick(3);
    scl = 1'b0;
    tick(1);
  endtask

  // byte msb first, then acknowledge slot
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(d[i], s);
    end
    xfer_bit(1'b1, s);
    ack = ~s;
  endtask

  // device sends, master acks or ends
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(1'b1, s);
      d[i] = s;
    end
    xfer_bit(last, s);
  endtask

  // data line held low with clock low
  task automatic hold_low(input int n);
    m_pull = 1'b1;
    tick(n);
    m_pull = 1'b0;
  endtask
endmodule

// >>> test/tb_charger_i2c_status_fault_regs.sv
`timescale 1ns/1ps
module tb_charger_i2c_status_fault_regs
  import cis_pkg::*;
;
  logic      mclk, lclk, arst_n, scl, m_pull, sda_o, sda_oe, ship, int_req;
  wire logic sda;
  cis_cond_t cond;
  int        miscompares = 0;
  int        comparisons = 0;

  assign sda = ~m_pull & (sda_oe ? sda_o : 1'b1);

  cis_bus_master i_bm (.mclk(mclk), .sda(sda), .scl(scl), .m_pull(m_pull));

  cis_charger_i2c i_dut (
    .mclk(mclk), .arst_n(arst_n), .lclk(lclk), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .cond(cond), .ship_mode_request(ship),
    .int_req(int_req));
  // ---------------------------------------------------------------
  // clocks and helpers
  // ---------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    lclk = 1'b0;
    #3;
    forever #7.5 lclk = ~lclk;
  end

  task automatic give_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    logic a0, a1, a2;
    i_bm.start();
    i_bm.wbyte({SLAVE_ADDR, 1'b0}, a0);
    i_bm.wbyte(a, a1);
    i_bm.wbyte(d, a2);
    i_bm.stop();
    check({7'h00, a0 & a1 & a2}, 8'h01);
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    logic a0;
    i_bm.start();
    i_bm.wbyte({SLAVE_ADDR, 1'b0}, a0);
    i_bm.wbyte(a, a0);
    i_bm.start();
    i_bm.wbyte({SLAVE_ADDR, 1'b1}, a0);
    i_bm.rbyte(1'b1, d);
    i_bm.stop();
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] d;
    check({5'h00, ship, int_req, sda_oe}, 8'h00);
    rd_reg(REG_FAULT, d);
    check(d, 8'h00);
  endtask

  task automatic t_addr();
    logic ack;
    i_bm.start();
    i_bm.wbyte(8'hA0, ack);
    check({7'h00, ack}, 8'h00);
    i_bm.wbyte({SLAVE_ADDR, 1'b0}, ack);
    check({7'h00, ack}, 8'h00);
    i_bm.stop();
  endtask

  task automatic t_live();
    logic [7:0] d;
    for (int i = 0; i < 4; i++) begin
      cond.charge_state      = i[1:0];
      cond.input_dpm_active  = i[0];
      cond.disable_pin_state = i[1];
      cond.switcher_on_state = ~i[0];
      rd_reg(REG_STATUS, d);
      check(d, {i[1:0], 3'b000, i[0], i[1], ~i[0]});
    end
    cond = '0;
  endtask

  task automatic t_ship();
    logic [7:0] d;
    wr_reg(REG_STATUS, 8'h20);
    check({7'h00, ship}, 8'h01);
    rd_reg(REG_STATUS, d);
    check(d, 8'h00);
    wr_reg(REG_STATUS, 8'h00);
    check({7'h00, ship}, 8'h00);
  endtask

  task automatic t_flags();
    logic [7:0] d;
    cond.battery_oc = 1'b1;
    tick(1);
    cond.battery_oc = 1'b0;
    tick(3);
    check({7'h00, int_req}, 8'h01);
    rd_reg(REG_STATUS, d);
    check(d, 8'hC0);
    rd_reg(REG_FAULT, d);
    check(d, 8'h10);
    rd_reg(REG_FAULT, d);
    check(d, 8'h00);
    cond.input_uv = 1'b1;
    rd_reg(REG_FAULT, d);
    check(d, 8'h40);
    rd_reg(REG_FAULT, d);
    check(d, 8'h00);
    cond.input_uv    = 1'b0;
    cond.input_ov    = 1'b1;
    cond.battery_low = 1'b1;
    rd_reg(REG_FAULT, d);
    rd_reg(REG_FAULT, d);
    check(d, 8'hA0);
    cond = '0;
    // latched flags report once more after the condition ends
    rd_reg(REG_FAULT, d);
    check(d, 8'hA0);
    rd_reg(REG_FAULT, d);
    check(d, 8'h00);
    wr_reg(REG_FAULT, 8'h0F);
    cond.battery_oc = 1'b1;
    tick(1);
    cond.battery_oc = 1'b0;
    tick(3);
    check({7'h00, int_req}, 8'h00);
    rd_reg(REG_STATUS, d);
    check(d, 8'h00);
    rd_reg(REG_FAULT, d);
    check(d, 8'h1F);
    wr_reg(REG_FAULT, 8'h00);
  endtask

  task automatic t_sticky();
    logic [7:0] d;
    cond.timer_fault = 1'b1;
    tick(1);
    cond.timer_fault = 1'b0;
    rd_reg(REG_STATUS, d);
    rd_reg(REG_STATUS, d);
    check(d, 8'hC8);
    cond.disable_pin_state = 1'b1;
    tick(3);
    cond.disable_pin_state = 1'b0;
    rd_reg(REG_STATUS, d);
    check(d, 8'h00);
    cond.reset_cond = 1'b1;
    tick(1);
    cond.reset_cond = 1'b0;
    rd_reg(REG_STATUS, d);
    check(d, 8'h10);
    rd_reg(REG_STATUS, d);
    check(d, 8'h00);
    rd_reg(8'h05, d);
    check(d, RD_UNMAPPED);
  endtask

  task automatic t_hang();
    logic ack;
    i_bm.start();
    i_bm.wbyte({SLAVE_ADDR, 1'b0}, ack);
    // longer than the default hang timeout
    i_bm.hold_low(700);
    i_bm.wbyte({SLAVE_ADDR, 1'b0}, ack);
    check({7'h00, ack}, 8'h00);
    i_bm.stop();
    i_bm.start();
    i_bm.wbyte({SLAVE_ADDR, 1'b0}, ack);
    i_bm.hold_low(10);
    i_bm.wbyte(REG_FAULT, ack);
    check({7'h00, ack}, 8'h01);
    i_bm.stop();
  endtask
  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    cond   = '0;
    tick(20);
    arst_n = 1'b1;
    tick(4);
    t_reset();
    t_addr();
    t_live();
    t_ship();
    t_flags();
    t_sticky();
    t_hang();
    give_verdict();
  end

  initial begin
    #3000000;
    miscompares++;
    give_verdict();
  end
endmodule
